// file: mgp_masked_gpio_data_port.sv
// Purpose: Masked data access for the X lines and the low eight Y lines
// Assumes: One clock; pin inputs are asynchronous and are synchronised
// Notes:   Read data appears one cycle after the read strobe
//
// Summary of operation
// - X data register at 0xC0, masked
// - Output pins drive the latch; writes change only enabled bits
// - Input pins read sampled level gated by mask
// - Bits 15..8 are X line enables
// - Bits 7..0 are X line pin data
// - Y data register at 0xC2, same behaviour
// - Bits 15..8 are Y line enables
// - Bits 7..0 are Y line pin data
// - Masks and data reset to zero
// - X direction at 0xC6, 1 is output
// - Y direction at 0xC7, 1 is output
module mgp_masked_gpio_data_port (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_rvalid,
    input  wire logic [7:0]  x_line_pins_in,
    output logic      [7:0]  x_line_pins_out,
    output logic      [7:0]  x_line_pins_oe,
    input  wire logic [7:0]  y_line_pins_in,
    output logic      [7:0]  y_line_pins_out,
    output logic      [7:0]  y_line_pins_oe
);

    logic [7:0]        x_sync1_ff;
    logic [7:0]        x_sync_ff;
    logic [7:0]        y_sync1_ff;
    logic [7:0]        y_sync_ff;
    logic [7:0]        x_mask_ff;
    logic [7:0]        y_mask_ff;
    logic [7:0]        x_out_ff;
    logic [7:0]        y_out_ff;
    logic [7:0]        x_dir_ff;
    logic [7:0]        y_dir_ff;
    logic [15:0]       reg_rdata_ff;
    logic              reg_rvalid_ff;
    logic [15:0]       nxt_rdata;
    mgp_pkg::mgp_dreg_t wr_word;
    logic              wr_x;
    logic              wr_y;
    logic              wr_xdir;
    logic              wr_ydir;

    // Only enabled bits take the new value; the others keep their latched value
    function automatic logic [7:0] masked_write(input logic [7:0] old_v,
                                                input logic [7:0] en,
                                                input logic [7:0] val);
        masked_write = (old_v & ~en) | (val & en);
    endfunction : masked_write

    // Outputs read back their driven level, inputs the synchronised pin
    function automatic logic [7:0] masked_read(input logic [7:0] en,
                                               input logic [7:0] dir,
                                               input logic [7:0] pin,
                                               input logic [7:0] drv);
        masked_read = en & ((dir & drv) | (~dir & pin));
    endfunction : masked_read

    assign wr_word = mgp_pkg::mgp_dreg_t'(reg_wdata);
    assign wr_x    = ce && reg_wr && (reg_addr == mgp_pkg::MGP_X_DATA_OFS);
    assign wr_y    = ce && reg_wr && (reg_addr == mgp_pkg::MGP_Y_DATA_OFS);
    assign wr_xdir = ce && reg_wr && (reg_addr == mgp_pkg::MGP_X_DIR_OFS);
    assign wr_ydir = ce && reg_wr && (reg_addr == mgp_pkg::MGP_Y_DIR_OFS);

    // Two-stage synchronisers on the pin inputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            x_sync1_ff <= mgp_pkg::MGP_SYNC_RST;
            x_sync_ff  <= mgp_pkg::MGP_SYNC_RST;
            y_sync1_ff <= mgp_pkg::MGP_SYNC_RST;
            y_sync_ff  <= mgp_pkg::MGP_SYNC_RST;
        end else if (ce) begin
            x_sync1_ff <= x_line_pins_in;
            x_sync_ff  <= x_sync1_ff;
            y_sync1_ff <= y_line_pins_in;
            y_sync_ff  <= y_sync1_ff;
        end
    end

    // X line data register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            x_mask_ff <= mgp_pkg::MGP_MASK_RST;
            x_out_ff  <= mgp_pkg::MGP_OUT_RST;
        end else if (wr_x) begin
            x_mask_ff <= wr_word.en;
            x_out_ff  <= masked_write(x_out_ff, wr_word.en,
                                      wr_word.val);
        end
    end

    // Y line data register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            y_mask_ff <= mgp_pkg::MGP_MASK_RST;
            y_out_ff  <= mgp_pkg::MGP_OUT_RST;
        end else if (wr_y) begin
            y_mask_ff <= wr_word.en;
            y_out_ff  <= masked_write(y_out_ff, wr_word.en,
                                      wr_word.val);
        end
    end

    // Direction registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            x_dir_ff <= mgp_pkg::MGP_DIR_RST;
            y_dir_ff <= mgp_pkg::MGP_DIR_RST;
        end else begin
            if (wr_xdir) begin
                x_dir_ff <= reg_wdata[7:0];
            end
            if (wr_ydir) begin
                y_dir_ff <= reg_wdata[7:0];
            end
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        if (reg_addr == mgp_pkg::MGP_X_DATA_OFS) begin
            nxt_rdata = {x_mask_ff,
                         masked_read(x_mask_ff, x_dir_ff,
                                     x_sync_ff, x_out_ff)};
        end else if (reg_addr == mgp_pkg::MGP_Y_DATA_OFS) begin
            nxt_rdata = {y_mask_ff,
                         masked_read(y_mask_ff, y_dir_ff,
                                     y_sync_ff, y_out_ff)};
        end else if (reg_addr == mgp_pkg::MGP_X_DIR_OFS) begin
            nxt_rdata = {mgp_pkg::MGP_ZERO_BYTE, x_dir_ff};
        end else if (reg_addr == mgp_pkg::MGP_Y_DIR_OFS) begin
            nxt_rdata = {mgp_pkg::MGP_ZERO_BYTE, y_dir_ff};
        end else begin
            nxt_rdata = mgp_pkg::MGP_RDATA_RST;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_ff  <= mgp_pkg::MGP_RDATA_RST;
            reg_rvalid_ff <= 1'b0;
        end else if (ce) begin
            reg_rvalid_ff <= reg_rd;
            if (reg_rd) begin
                reg_rdata_ff <= nxt_rdata;
            end
        end
    end

    assign reg_rdata       = reg_rdata_ff;
    assign reg_rvalid      = reg_rvalid_ff;
    // Driven level stays latched while a pin is input, ready for turnaround
    assign x_line_pins_out = x_out_ff;
    assign x_line_pins_oe  = x_dir_ff;
    assign y_line_pins_out = y_out_ff;
    assign y_line_pins_oe  = y_dir_ff;

    x_mask_wr_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_x |=> x_mask_ff == $past(reg_wdata[15:8]))
        else $error("x mask not taken from write");

    y_mask_wr_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_y |=> y_mask_ff == $past(reg_wdata[15:8]))
        else $error("y mask not taken from write");

    x_out_wr_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_x |=> x_line_pins_out ==
            (($past(x_out_ff) & ~$past(reg_wdata[15:8]))
             | ($past(reg_wdata[7:0]) & $past(reg_wdata[15:8]))))
        else $error("x pins not masked write");

    y_out_wr_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_y |=> y_line_pins_out ==
            (($past(y_out_ff) & ~$past(reg_wdata[15:8]))
             | ($past(reg_wdata[7:0]) & $past(reg_wdata[15:8]))))
        else $error("y pins not masked write");

    x_read_val_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && reg_rd && reg_addr == mgp_pkg::MGP_X_DATA_OFS
         && x_dir_ff == 8'h00)
        |=> reg_rvalid && reg_rdata ==
            {$past(x_mask_ff), $past(x_mask_ff) & $past(x_sync_ff)})
        else $error("x input read wrong");

    y_read_val_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && reg_rd && reg_addr == mgp_pkg::MGP_Y_DATA_OFS
         && y_dir_ff == 8'h00)
        |=> reg_rvalid && reg_rdata ==
            {$past(y_mask_ff), $past(y_mask_ff) & $past(y_sync_ff)})
        else $error("y input read wrong");

    rd_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && !reg_rd) |=> !reg_rvalid)
        else $error("read valid without read");

    masked_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && reg_rd && (reg_addr == mgp_pkg::MGP_X_DATA_OFS
                          || reg_addr == mgp_pkg::MGP_Y_DATA_OFS))
        |=> (reg_rdata[7:0] & ~reg_rdata[15:8]) == 8'h00)
        else $error("disabled pin read nonzero");

    x_dir_oe_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_xdir |=> x_line_pins_oe == $past(reg_wdata[7:0]))
        else $error("x direction not applied");

    y_dir_oe_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_ydir |=> y_line_pins_oe == $past(reg_wdata[7:0]))
        else $error("y direction not applied");

    y_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        !wr_y |=> $stable(y_line_pins_out) && $stable(y_mask_ff))
        else $error("y register changed without write");

    // No disable here: the check is meant to run while reset is held
    rst_clear_a: assert property (@(posedge clk)
        !rstn |-> x_line_pins_out == mgp_pkg::MGP_OUT_RST
                  && y_line_pins_out == mgp_pkg::MGP_OUT_RST
                  && x_line_pins_oe == mgp_pkg::MGP_DIR_RST
                  && y_line_pins_oe == mgp_pkg::MGP_DIR_RST
                  && !reg_rvalid)
        else $error("outputs not cleared in reset");

endmodule : mgp_masked_gpio_data_port

// file: mgp_pkg.sv
// Purpose: Shared constants and types for the masked GPIO data port
// Assumes: Byte-addressed register port from the host command interpreter
// Notes:   Data registers are 16 bits wide, direction registers 8 bits
package mgp_pkg;

    localparam logic [7:0]  MGP_X_DATA_OFS = 8'hC0;
    localparam logic [7:0]  MGP_Y_DATA_OFS = 8'hC2;
    localparam logic [7:0]  MGP_X_DIR_OFS  = 8'hC6;
    localparam logic [7:0]  MGP_Y_DIR_OFS  = 8'hC7;

    localparam logic [7:0]  MGP_MASK_RST   = 8'h00;
    localparam logic [7:0]  MGP_OUT_RST    = 8'h00;
    localparam logic [7:0]  MGP_DIR_RST    = 8'h00;
    localparam logic [7:0]  MGP_SYNC_RST   = 8'h00;
    localparam logic [15:0] MGP_RDATA_RST  = 16'h0000;
    localparam logic [7:0]  MGP_ZERO_BYTE  = 8'h00;

    // Upper byte holds the per-pin enables, lower byte the pin values
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] val;
    } mgp_dreg_t;

endpackage : mgp_pkg

// file: mgp_pin_partner.sv
// Purpose: External circuitry seen by one group of eight pins
// Assumes: Outside drivers are overridden wherever the port drives
// Notes:   Undriven pins follow the level set by the bench
module mgp_pin_partner (
    input  wire logic [7:0] ext,
    input  wire logic [7:0] drv_out,
    input  wire logic [7:0] drv_oe,
    output logic      [7:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pin_lvl = (drv_oe & drv_out) | (~drv_oe & ext);
endmodule : mgp_pin_partner

// file: masked_gpio_data_port_tb.sv
// Purpose: Self-checking bench for the masked GPIO data port
// Assumes: Strobes are driven on the falling edge, one request per call
// Notes:   Model keeps mask, latch, direction and outside levels
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    err_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module masked_gpio_data_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rstn, ce, reg_wr, reg_rd, reg_rvalid;
    logic [7:0]  reg_addr, x_out, x_oe, y_out, y_oe, x_in, y_in;
    logic [15:0] reg_wdata, reg_rdata;
    logic [7:0]  msk[2], lat[2], dir[2], ext[2];
    logic [7:0]  adr_tab[6] = '{8'hC0, 8'hC2, 8'hC6, 8'hC7, 8'hC4, 8'h55};
    logic [31:0] r;
    int          err_count, total_checks;
    integer      seed;

    mgp_masked_gpio_data_port mgp_masked_gpio_data_port_i (
        .clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .x_line_pins_in(x_in), .x_line_pins_out(x_out),
        .x_line_pins_oe(x_oe), .y_line_pins_in(y_in),
        .y_line_pins_out(y_out), .y_line_pins_oe(y_oe));
    mgp_pin_partner mgp_pin_partner_i (
        .ext(ext[0]), .drv_out(x_out), .drv_oe(x_oe), .pin_lvl(x_in));
    mgp_pin_partner mgp_pin_partner_y_i (
        .ext(ext[1]), .drv_out(y_out), .drv_oe(y_oe), .pin_lvl(y_in));

    task complete_run;
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // Output pins read back the latch, input pins the outside level
    function logic [15:0] expect_rd(input logic [7:0] a);
        int k;
        k = a[1];
        case (a)
            8'hC0, 8'hC2: return {msk[k], msk[k] & ((dir[k] & lat[k]) |
                                  (~dir[k] & ext[k]))};
            8'hC6, 8'hC7: return {8'h00, dir[a[0]]};
            default: return 16'h0000;
        endcase
    endfunction : expect_rd

    task model_clear;
        for (int k = 0; k < 2; k++) begin
            msk[k] = 8'h00;
            lat[k] = 8'h00;
            dir[k] = 8'h00;
        end
    endtask : model_clear

    task wr(input logic [7:0] a, input logic [15:0] d);
        mgp_pkg::mgp_dreg_t w;
        w = d;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        if (a == 8'hC0 || a == 8'hC2) begin
            msk[a[1]] = w.en;
            lat[a[1]] = (lat[a[1]] & ~w.en) | (w.val & w.en);
        end
        if (a == 8'hC6 || a == 8'hC7) begin
            dir[a[0]] = d[7:0];
        end
        `CHK(x_out, lat[0])
        `CHK(y_out, lat[1])
        `CHK(x_oe, dir[0])
        `CHK(y_oe, dir[1])
        // Idle cycle so the next call never re-raises the strobe at once
        @(negedge clk);
    endtask : wr

    task rd(input logic [7:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        `CHK(reg_rvalid, 1'b1)
        `CHK(reg_rdata, expect_rd(a))
        @(negedge clk);
        `CHK(reg_rvalid, 1'b0)
    endtask : rd

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        seed = 32'h31a7_eda4;
        err_count = 0;
        total_checks = 0;
        rstn = 1'b0;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        ext[0] = 8'hA5;
        ext[1] = 8'h3C;
        model_clear;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        rd(8'hC0);
        rd(8'hC2);
        wr(8'hC0, 16'hFF0F);
        wr(8'hC6, 16'h00FF);
        rd(8'hC0);
        for (int n = 0; n < 120; n++) begin
            r = $random(seed);
            ext[0] = r[7:0];
            ext[1] = r[15:8];
            repeat (2) @(negedge clk);
            `CHK(reg_rvalid, 1'b0)
            r = $random(seed);
            if (r[31]) begin
                wr(adr_tab[r[23:16] % 6], r[15:0]);
            end else begin
                rd(adr_tab[r[23:16] % 6]);
            end
        end
        // A write strobe while the clock enable is low must change nothing
        ce = 1'b0;
        reg_addr = 8'hC0;
        reg_wdata = {8'hFF, ~lat[0]};
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        ce = 1'b1;
        `CHK(x_out, lat[0])
        `CHK(reg_rvalid, 1'b0)
        @(negedge clk);
        rd(8'hC0);
        // Reset in mid-run must clear latch, mask and direction again
        rstn = 1'b0;
        model_clear;
        @(negedge clk);
        rstn = 1'b1;
        rd(8'hC2);
        rd(8'hC6);
        wr(8'hC7, 16'h0000);
        complete_run;
    end
endmodule : masked_gpio_data_port_tb
